/* design/mssp_port_cfg.sv */
`timescale 1ns/1ps
module mssp_port_cfg
	import mssp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       step,
	input  wire logic       enable,
	input  wire logic       hit,
	input  mssp_pcmd_t      cmd,
	input  mssp_tap_t       tap,
	input  wire logic       tms_in,
	output mssp_port_t      state_r,
	output logic            local_mode_select_out_r
);
	mssp_port_t state_nxt;
	logic       act;

	always_comb
	begin
		act       = step && enable && hit;
		state_nxt = state_r;
		unique case (state_r)
			port_unparked:
			begin
				if (act && cmd == pcmd_park_reset && tap == tap_idle)
					state_nxt = park_in_reset_state;
				else if (act && cmd == idle_park_cmd && tap == tap_idle)
					state_nxt = park_in_idle_state;
				else if (act && cmd == pcmd_park_pause && tap == tap_pa_dr)
					state_nxt = park_in_data_pause;
				else if (act && cmd == pcmd_park_pause && tap == tap_pa_ir)
					state_nxt = park_in_instr_pause;
			end
			park_in_reset_state, park_in_idle_state:
				if (act && cmd == pcmd_unpark && tap == tap_idle)
					state_nxt = port_unparked;
			park_in_data_pause:
				if (act && cmd == pcmd_unpark && tap == tap_pa_dr)
					state_nxt = port_unparked;
			park_in_instr_pause:
				if (act && cmd == pcmd_unpark && tap == tap_pa_ir)
					state_nxt = port_unparked;
			default:
				state_nxt = park_in_reset_state;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state_r <= park_in_reset_state;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			local_mode_select_out_r <= 1'b1;
		else if (state_r == port_unparked)
			local_mode_select_out_r <= tms_in;
		else
			local_mode_select_out_r <= (state_r == park_in_reset_state);
	end
endmodule // mssp_port_cfg

/* design/mssp_tap.sv */
`timescale 1ns/1ps
module mssp_tap
	import mssp_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      rst_n,
	input  wire logic      step,
	input  wire logic      tms,
	input  wire logic      trst_n,
	output mssp_tap_t      state_r
);
	mssp_tap_t state_nxt;

	always_comb
	begin
		unique case (state_r)
			tap_reset:  state_nxt = tms ? tap_reset : tap_idle;
			tap_idle:   state_nxt = tms ? tap_sel_dr : tap_idle;
			tap_sel_dr: state_nxt = tms ? tap_sel_ir : tap_cap_dr;
			tap_cap_dr: state_nxt = tms ? tap_ex1_dr : tap_sh_dr;
			tap_sh_dr:  state_nxt = tms ? tap_ex1_dr : tap_sh_dr;
			tap_ex1_dr: state_nxt = tms ? tap_upd_dr : tap_pa_dr;
			tap_pa_dr:  state_nxt = tms ? tap_ex2_dr : tap_pa_dr;
			tap_ex2_dr: state_nxt = tms ? tap_upd_dr : tap_sh_dr;
			tap_upd_dr: state_nxt = tms ? tap_sel_dr : tap_idle;
			tap_sel_ir: state_nxt = tms ? tap_reset : tap_cap_ir;
			tap_cap_ir: state_nxt = tms ? tap_ex1_ir : tap_sh_ir;
			tap_sh_ir:  state_nxt = tms ? tap_ex1_ir : tap_sh_ir;
			tap_ex1_ir: state_nxt = tms ? tap_upd_ir : tap_pa_ir;
			tap_pa_ir:  state_nxt = tms ? tap_ex2_ir : tap_pa_ir;
			tap_ex2_ir: state_nxt = tms ? tap_upd_ir : tap_sh_ir;
			tap_upd_ir: state_nxt = tms ? tap_sel_dr : tap_idle;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state_r <= tap_reset;
		else if (!trst_n)
			state_r <= tap_reset;
		else if (step)
			state_r <= state_nxt;
	end
endmodule // mssp_tap

/* design/mssp_top.sv */
`timescale 1ns/1ps
module mssp_top
	import mssp_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  tck_b,
	input  wire logic                  tms_b,
	input  wire logic                  tdi_b,
	input  wire logic                  trst_b_n,
	output logic                       tdo_b_o,
	output logic                       tdo_b_oe,
	input  wire logic [ADDR_W-1:0]     slot_addr,
	input  wire logic [1:0]            group_num,
	input  wire logic                  group_member,
	input  wire logic                  local_oe_n,
	input  wire logic [NUM_PORTS-1:0]  local_tdi_in,
	output logic [NUM_PORTS-1:0]       local_tdo_out,
	output logic [NUM_PORTS-1:0]       local_tck_out,
	output logic [NUM_PORTS-1:0]       local_trst_n_out,
	output logic [NUM_PORTS-1:0]       local_mode_select_out,
	output logic [NUM_PORTS-1:0]       local_port_oe,
	output logic [NUM_PORTS-1:0]       port_hiz_notify,
	output logic [NUM_PORTS-1:0]       port_analog_bus_enable,
	output logic                       device_selected,
	output logic                       device_selected_single,
	output logic                       signature_run,
	output logic                       clock_count_run,
	output mssp_dr_t                   dr_select,
	output mssp_tap_t                  tap_state
);
	// Pin synchronisers
	logic [SYNC_W-1:0]    sync_m1_r;
	logic [SYNC_W-1:0]    sync_s_r;
	logic [SYNC_W-1:0]    pins;
	logic                 tck_s;
	logic                 tms_s;
	logic                 tdi_s;
	logic                 trst_s_n;
	logic [ADDR_W-1:0]    slot_s;
	logic [1:0]           group_s;
	logic                 member_s;
	logic                 oe_n_s;
	logic [NUM_PORTS-1:0] ltdi_s;
	logic                 tck_d_r;
	logic                 tck_rise;
	logic                 tck_fall;

	assign pins = {tck_b, tms_b, tdi_b, trst_b_n, slot_addr, group_num, group_member,
		local_oe_n, local_tdi_in};

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync_m1_r <= '0;
			sync_s_r  <= '0;
			tck_d_r   <= 1'b0;
		end
		else
		begin
			sync_m1_r <= pins;
			sync_s_r  <= sync_m1_r;
			tck_d_r   <= tck_s;
		end
	end

	assign {tck_s, tms_s, tdi_s, trst_s_n, slot_s, group_s, member_s, oe_n_s, ltdi_s} = sync_s_r;
	assign tck_rise = tck_s && !tck_d_r;
	assign tck_fall = !tck_s && tck_d_r;

	// TAP controller
	mssp_tap u_tap (
		.clk     (clk),
		.rst_n   (rst_n),
		.step    (tck_rise),
		.tms     (tms_s),
		.trst_n  (trst_s_n),
		.state_r (tap_state)
	);

	// Instruction register
	logic [IR_W-1:0]   ir_sh_r;
	logic [IR_W-1:0]   ir_r;
	logic              bypass_r;
	logic              selected;
	logic              upd_ir_fall;
	mssp_sel_t         sel_r;
	mssp_sel_t         sel_nxt;
	logic [NUM_PORTS:0] feed;

	assign upd_ir_fall = tck_fall && tap_state == tap_upd_ir;
	assign selected    = sel_r == sel_single || sel_r == sel_group;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ir_sh_r <= IR_CAPTURE;
		else if (tck_rise && tap_state == tap_cap_ir)
			ir_sh_r <= IR_CAPTURE;
		else if (tck_rise && tap_state == tap_sh_ir)
			ir_sh_r <= {feed[NUM_PORTS], ir_sh_r[IR_W-1:1]};
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ir_r <= BYPASS_CMD;
		else if (tap_state == tap_reset)
			ir_r <= BYPASS_CMD;
		else if (upd_ir_fall)
			ir_r <= ir_sh_r;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			bypass_r <= 1'b0;
		else if (tck_rise && tap_state == tap_cap_dr)
			bypass_r <= 1'b0;
		else if (tck_rise && tap_state == tap_sh_dr)
			bypass_r <= feed[NUM_PORTS];
	end

	// Selection machine
	logic addr_single;
	logic addr_group;

	assign addr_single = ir_sh_r[ADDR_W-1:0] == slot_s;
	assign addr_group  = ir_sh_r[ADDR_W-1:0] == ADDR_BROADCAST
		|| (ir_sh_r[ADDR_W-1:2] == ADDR_GROUP_HI && member_s && ir_sh_r[1:0] == group_s);

	always_comb
	begin
		sel_nxt = sel_r;
		if (tap_state == tap_reset)
			sel_nxt = sel_addr_wait;
		else if (upd_ir_fall)
		begin
			unique case (sel_r)
				sel_addr_wait:
					if (addr_group)
						sel_nxt = sel_group;
					else if (addr_single)
						sel_nxt = sel_single;
					else
						sel_nxt = sel_unselected;
				sel_unselected, sel_single, sel_group:
					if (ir_sh_r == RETURN_TO_ADDR_WAIT_CMD)
						sel_nxt = sel_addr_wait;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sel_r <= sel_addr_wait;
		else
			sel_r <= sel_nxt;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			device_selected        <= 1'b0;
			device_selected_single <= 1'b0;
		end
		else
		begin
			device_selected        <= selected;
			device_selected_single <= sel_r == sel_single;
		end
	end

	// Level-2 decode, only while selected
	mssp_pcmd_t pcmd;

	assign pcmd = selected ? mssp_pcmd_of(ir_r) : pcmd_none;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			dr_select <= dr_bypass;
		else if (!selected)
			dr_select <= dr_bypass;
		else
			dr_select <= mssp_dr_of(ir_r);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			signature_run <= 1'b0;
		else if (upd_ir_fall && selected && ir_sh_r == SIGNATURE_START_CMD)
			signature_run <= 1'b1;
		else if (upd_ir_fall && selected && ir_sh_r == SIGNATURE_STOP_CMD)
			signature_run <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			clock_count_run <= 1'b0;
		else if (upd_ir_fall && selected && ir_sh_r == CLOCK_COUNT_START_CMD)
			clock_count_run <= 1'b1;
		else if (upd_ir_fall && selected && ir_sh_r == CLOCK_COUNT_STOP_CMD)
			clock_count_run <= 1'b0;
	end

	// Port configuration machines and chain
	mssp_port_t           port_state [NUM_PORTS];
	logic [NUM_PORTS-1:0] unparked;
	logic [NUM_PORTS-1:0] in_chain;

	assign feed[0] = tdi_s;

	genvar k;
	generate
		for (k = 0; k < NUM_PORTS; k++)
		begin : g_port
			mssp_port_cfg u_cfg (
				.clk                     (clk),
				.rst_n                   (rst_n),
				.step                    (tck_rise),
				.enable                  (selected),
				.hit                     (ir_r[k]),
				.cmd                     (pcmd),
				.tap                     (tap_state),
				.tms_in                  (tms_s),
				.state_r                 (port_state[k]),
				.local_mode_select_out_r (local_mode_select_out[k])
			);
			assign unparked[k] = port_state[k] == port_unparked;
			assign in_chain[k] = unparked[k] && selected;
			assign feed[k+1]   = in_chain[k] ? ltdi_s[k] : feed[k];
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			local_tdo_out <= '0;
		else if (tck_fall)
			local_tdo_out <= feed[NUM_PORTS-1:0];
	end

	// Backplane data out, only when singly selected
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tdo_b_o  <= 1'b0;
			tdo_b_oe <= 1'b0;
		end
		else if (tck_fall)
		begin
			tdo_b_o  <= (tap_state == tap_sh_ir) ? ir_sh_r[0] : bypass_r;
			tdo_b_oe <= sel_r == sel_single
				&& (tap_state == tap_sh_ir || tap_state == tap_sh_dr);
		end
	end

	// Local port pins
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			local_tck_out          <= '0;
			local_trst_n_out       <= '0;
			local_port_oe          <= '0;
			port_hiz_notify        <= '1;
			port_analog_bus_enable <= '0;
		end
		else
		begin
			local_tck_out          <= {NUM_PORTS{tck_s}};
			local_trst_n_out       <= {NUM_PORTS{trst_s_n}};
			local_port_oe          <= {NUM_PORTS{!oe_n_s}};
			port_hiz_notify        <= {NUM_PORTS{oe_n_s}};
			port_analog_bus_enable <= unparked & {NUM_PORTS{!oe_n_s}};
		end
	end
endmodule // mssp_top

/* inc/mssp_pkg.sv */
// Notes on behaviour
// - High-impedance notify high while local outputs float.
// - One analog-bus enable output per local port.
// - Full TAP plus Level-1 and Level-2 protocols.
// - Select single, group or all before port control.
// - Select only on slot or group address match.
// - Three independent port configuration machines.
// - One presented chain; unparked ports concatenated in it.
// - Four park states, per port or together.
// - Parking removes chain; unparking inserts it.
// - Each port machine holds its own state.
// - Idle-parked port unparks only in Run-Test/Idle.
// - Idle park at Run-Test/Idle; local mode-select held low.
// - Port machines enabled only while device selected.
// - Port transitions gated by TAP state.
// - Reset: TAP reset, address wait, ports park-reset.
// - Decode all Level-2 register and control instructions.
// - Compare seven low instruction bits with slot.
// - No scan-out before selection; low bits discarded.
// - Match broadcast and the one group code set by group_num too.
// - Return to address wait on reset state or command.
package mssp_pkg;
	localparam int IR_W      = 8;
	localparam int ADDR_W    = 7;
	localparam int NUM_PORTS = 3;
	localparam int SYNC_W    = 18;

	localparam logic [IR_W-1:0]   IR_CAPTURE     = 8'h01;
	localparam logic [ADDR_W-1:0] ADDR_BROADCAST = 7'h3B;
	localparam logic [4:0]        ADDR_GROUP_HI  = 5'h0F;

	// Level-2 opcodes
	localparam logic [IR_W-1:0] BYPASS_CMD                  = 8'hFF;
	localparam logic [IR_W-1:0] EXTEST_CMD                  = 8'h00;
	localparam logic [IR_W-1:0] SAMPLE_CMD                  = 8'h81;
	localparam logic [IR_W-1:0] IDENT_CMD                   = 8'hE6;
	localparam logic [IR_W-1:0] SELECT_PORT_CONFIG_REG_CMD  = 8'h8E;
	localparam logic [IR_W-1:0] SELECT_GROUP_REG_CMD        = 8'h03;
	localparam logic [IR_W-1:0] SELECT_SIGNATURE_REG_CMD    = 8'h82;
	localparam logic [IR_W-1:0] SIGNATURE_START_CMD         = 8'h0C;
	localparam logic [IR_W-1:0] SIGNATURE_STOP_CMD          = 8'h0D;
	localparam logic [IR_W-1:0] SELECT_CLOCK_COUNT_REG_CMD  = 8'hCE;
	localparam logic [IR_W-1:0] CLOCK_COUNT_START_CMD       = 8'h08;
	localparam logic [IR_W-1:0] CLOCK_COUNT_STOP_CMD        = 8'h09;
	localparam logic [IR_W-1:0] RETURN_TO_ADDR_WAIT_CMD     = 8'hC3;
	// Park opcodes: upper five bits, low three bits are the port mask
	localparam logic [4:0] PARK_RESET_OP = 5'h14;
	localparam logic [4:0] IDLE_PARK_OP  = 5'h15;
	localparam logic [4:0] PAUSE_PARK_OP = 5'h16;
	localparam logic [4:0] UNPARK_OP     = 5'h17;

	typedef enum logic [3:0] {
		tap_reset, tap_idle, tap_sel_dr, tap_cap_dr, tap_sh_dr, tap_ex1_dr, tap_pa_dr,
		tap_ex2_dr, tap_upd_dr, tap_sel_ir, tap_cap_ir, tap_sh_ir, tap_ex1_ir, tap_pa_ir,
		tap_ex2_ir, tap_upd_ir
	} mssp_tap_t;
	typedef enum logic [1:0] {sel_addr_wait, sel_unselected, sel_single, sel_group} mssp_sel_t;
	typedef enum logic [2:0] {
		port_unparked, park_in_reset_state, park_in_idle_state, park_in_data_pause,
		park_in_instr_pause
	} mssp_port_t;
	typedef enum logic [2:0] {pcmd_none, pcmd_park_reset, idle_park_cmd, pcmd_park_pause,
		pcmd_unpark} mssp_pcmd_t;
	typedef enum logic [2:0] {dr_bypass, dr_boundary, dr_ident, dr_port_cfg, dr_group,
		dr_signature, dr_clock_count} mssp_dr_t;

	function automatic mssp_pcmd_t mssp_pcmd_of(input logic [IR_W-1:0] ir);
		unique case (ir[7:3])
			PARK_RESET_OP: return pcmd_park_reset;
			IDLE_PARK_OP:  return idle_park_cmd;
			PAUSE_PARK_OP: return pcmd_park_pause;
			UNPARK_OP:     return pcmd_unpark;
			default:       return pcmd_none;
		endcase
	endfunction

	function automatic mssp_dr_t mssp_dr_of(input logic [IR_W-1:0] ir);
		unique case (ir)
			EXTEST_CMD, SAMPLE_CMD:     return dr_boundary;
			IDENT_CMD:                  return dr_ident;
			SELECT_PORT_CONFIG_REG_CMD: return dr_port_cfg;
			SELECT_GROUP_REG_CMD:       return dr_group;
			SELECT_SIGNATURE_REG_CMD:   return dr_signature;
			SELECT_CLOCK_COUNT_REG_CMD: return dr_clock_count;
			default:                    return dr_bypass;
		endcase
	endfunction
endpackage

/* verif/mssp_chain_model.sv */
`timescale 1ns/1ps
module mssp_chain_model
	import mssp_pkg::*;
(
	input wire logic                 clk,
	input wire logic                 rst_n,
	input wire logic [NUM_PORTS-1:0] local_tck_out,
	input wire logic [NUM_PORTS-1:0] local_tdo_out,
	input wire logic [NUM_PORTS-1:0] local_port_oe,
	output logic [NUM_PORTS-1:0]     local_tdi_in
);
	logic [NUM_PORTS-1:0] tck_d_r;
	logic [NUM_PORTS-1:0] chain_r;

	// One-bit chain per port, shifts on local clock rise
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tck_d_r <= 3'h0;
			chain_r <= 3'h0;
		end
		else
		begin
			tck_d_r <= local_tck_out;
			for (int i = 0; i < NUM_PORTS; i++)
				if (local_tck_out[i] && !tck_d_r[i] && local_port_oe[i])
					chain_r[i] <= local_tdo_out[i];
		end
	end
	assign local_tdi_in = chain_r;
endmodule // mssp_chain_model

/* verif/mssp_top_sva.sv */
`timescale 1ns/1ps
module mssp_top_sva
	import mssp_pkg::*;
(
	input wire logic                 clk,
	input wire logic                 rst_n,
	input wire logic                 tck_b,
	input wire logic                 tdo_b_oe,
	input wire logic [NUM_PORTS-1:0] local_tck_out,
	input wire logic [NUM_PORTS-1:0] local_port_oe,
	input wire logic [NUM_PORTS-1:0] port_hiz_notify,
	input wire logic [NUM_PORTS-1:0] port_analog_bus_enable,
	input wire logic                 device_selected,
	input wire logic                 device_selected_single,
	input mssp_dr_t                  dr_select,
	input mssp_tap_t                 tap_state
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_hiz_notify: assert property (port_hiz_notify == ~local_port_oe)
		else $error("hiz notify not inverse of local enable");
	a_abe_gated: assert property ((port_analog_bus_enable & ~local_port_oe) == 3'h0)
		else $error("analog enable high on floated port");
	a_tdo_single: assert property (tdo_b_oe |-> device_selected_single)
		else $error("backplane data driven while not singly selected");
	a_single_sel: assert property (device_selected_single |-> device_selected)
		else $error("single select without select");
	a_tlr_unsel: assert property ($rose(tap_state == tap_reset) |-> ##[0:4] !device_selected)
		else $error("selection kept after tap reset");
	a_unsel_bypass: assert property ($fell(device_selected) |-> ##[0:3] dr_select == dr_bypass)
		else $error("data register kept after deselect");
	a_unpark_sel: assert property ($rose(port_analog_bus_enable[0]) && $past(local_port_oe[0])
		|-> device_selected)
		else $error("port unparked while not selected");
	a_tck_copy: assert property (local_tck_out == {3{$past(tck_b, 3)}})
		else $error("local clock not a delayed copy of test clock");

	c_single: cover property (device_selected_single);
	c_tdo: cover property (tdo_b_oe);
	c_abe: cover property ($rose(port_analog_bus_enable[2]));
endmodule // mssp_top_sva

bind mssp_top mssp_top_sva i_sva (.clk, .rst_n, .tck_b, .tdo_b_oe, .local_tck_out, .local_port_oe,
	.port_hiz_notify, .port_analog_bus_enable, .device_selected, .device_selected_single,
	.dr_select, .tap_state);

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench
	import mssp_pkg::*;
;
	logic       clk, rst_n, tck_b, tms_b, tdi_b, group_member, local_oe_n, oe_seen, trst_b_n;
	logic       tdo_seen;
	logic [7:0] tdo_cap;
	logic       tdo_b_o, tdo_b_oe, device_selected, device_selected_single;
	logic       signature_run, clock_count_run;
	logic [2:0] local_tdi_in, local_tdo_out, local_tck_out, local_trst_n_out;
	logic [2:0] local_mode_select_out, local_port_oe, port_hiz_notify, port_analog_bus_enable;
	mssp_dr_t   dr_select;
	mssp_tap_t  tap_state;
	int         err_count, n_compared, n_live;

	mssp_top i_dut (.clk, .rst_n, .tck_b, .tms_b, .tdi_b, .trst_b_n, .tdo_b_o, .tdo_b_oe,
		.slot_addr(7'h12), .group_num(2'h2), .group_member, .local_oe_n, .local_tdi_in,
		.local_tdo_out, .local_tck_out, .local_trst_n_out, .local_mode_select_out, .local_port_oe,
		.port_hiz_notify, .port_analog_bus_enable, .device_selected, .device_selected_single,
		.signature_run, .clock_count_run, .dr_select, .tap_state);
	mssp_chain_model i_chain (.clk, .rst_n, .local_tck_out, .local_tdo_out, .local_port_oe,
		.local_tdi_in);

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk)
		if (tdo_b_oe === 1'b1)
			oe_seen <= 1'b1;

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp)
		begin
			$display("FAIL %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask

	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// One test clock period of 200 ns
	task automatic bit_tx(input logic tm, input logic td);
		@(posedge clk);
		tms_b <= tm;
		tdi_b <= td;
		repeat (3) @(posedge clk);
		tdo_seen = tdo_b_o;
		tck_b <= 1'b1;
		repeat (4) @(posedge clk);
		tck_b <= 1'b0;
	endtask

	task automatic tap_to_reset;
		repeat (5) bit_tx(1'b1, 1'b0);
		bit_tx(1'b0, 1'b0);
	endtask

	// Trailing bits: one per unparked port, plus one for the falling-edge retime when any port is unparked
	task automatic scan_ir(input logic [7:0] v);
		int n;
		n = 8 + n_live + ((n_live > 0) ? 1 : 0);
		bit_tx(1'b1, 1'b0);
		bit_tx(1'b1, 1'b0);
		bit_tx(1'b0, 1'b0);
		bit_tx(1'b0, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			bit_tx(i == n - 1, (i < 8) ? v[i] : 1'b0);
			if (i < 8)
				tdo_cap[i] = tdo_seen;
		end
		bit_tx(1'b1, 1'b0);
		bit_tx(1'b0, 1'b0);
		bit_tx(1'b0, 1'b0);
		repeat (6) @(posedge clk);
	endtask

	task automatic t_unsel;
		tap_to_reset();
		oe_seen = 1'b0;
		scan_ir(8'h05);
		chk("selected", 8'h0, device_selected);
		scan_ir({UNPARK_OP, 3'h7});
		chk("abe", 8'h0, port_analog_bus_enable);
		chk("lms", 8'h7, local_mode_select_out);
		chk("oe_seen", 8'h0, oe_seen);
		$display("t_unsel done");
	endtask

	task automatic t_single;
		logic [6:0] walk;
		logic [7:0] walk_ir;
		walk = 7'b0110101;
		walk_ir = 8'h6B;
		tap_to_reset();
		scan_ir(8'h92);
		chk("single", 8'h1, device_selected_single);
		scan_ir({UNPARK_OP, 3'h5});
		n_live = 2;
		chk("abe", 8'h5, port_analog_bus_enable);
		chk("oe_seen", 8'h1, oe_seen);
		local_oe_n <= 1'b1;
		repeat (6) @(posedge clk);
		chk("hiz", 8'h7, port_hiz_notify);
		chk("abe", 8'h0, port_analog_bus_enable);
		local_oe_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk("abe", 8'h5, port_analog_bus_enable);
		scan_ir({IDLE_PARK_OP, 3'h1});
		n_live = 1;
		chk("abe", 8'h4, port_analog_bus_enable);
		chk("lms", 8'h2, local_mode_select_out[1:0]);
		scan_ir({PAUSE_PARK_OP, 3'h4});
		n_live = 0;
		for (int i = 0; i < 7; i++)
			bit_tx(walk[i], 1'b0);
		repeat (6) @(posedge clk);
		chk("abe", 8'h0, port_analog_bus_enable);
		chk("lms", 8'h2, local_mode_select_out);
		scan_ir({UNPARK_OP, 3'h1});
		n_live = 1;
		chk("abe", 8'h1, port_analog_bus_enable);
		scan_ir({PAUSE_PARK_OP, 3'h1});
		n_live = 0;
		for (int i = 0; i < 8; i++)
			bit_tx(walk_ir[i], 1'b0);
		repeat (6) @(posedge clk);
		chk("abe", 8'h0, port_analog_bus_enable);
		chk("lms", 8'h2, local_mode_select_out);
		$display("t_single done");
	endtask

	task automatic t_decode;
		logic [7:0] ops [8];
		mssp_dr_t   drs [8];
		ops = '{EXTEST_CMD, SAMPLE_CMD, IDENT_CMD, SELECT_PORT_CONFIG_REG_CMD,
			SELECT_GROUP_REG_CMD, SELECT_SIGNATURE_REG_CMD, SELECT_CLOCK_COUNT_REG_CMD, BYPASS_CMD};
		drs = '{dr_boundary, dr_boundary, dr_ident, dr_port_cfg, dr_group, dr_signature,
			dr_clock_count, dr_bypass};
		for (int i = 0; i < 8; i++)
		begin
			scan_ir(ops[i]);
			chk("dr_select", drs[i], dr_select);
		end
		chk("tdo", IR_CAPTURE, tdo_cap);
		scan_ir(SIGNATURE_START_CMD);
		scan_ir(CLOCK_COUNT_START_CMD);
		chk("runs", 8'h3, {signature_run, clock_count_run});
		scan_ir(SIGNATURE_STOP_CMD);
		chk("runs", 8'h1, {signature_run, clock_count_run});
		scan_ir(CLOCK_COUNT_STOP_CMD);
		chk("runs", 8'h0, {signature_run, clock_count_run});
		$display("t_decode done");
	endtask

	task automatic t_group;
		scan_ir(RETURN_TO_ADDR_WAIT_CMD);
		chk("selected", 8'h0, device_selected);
		scan_ir(8'h3B);
		chk("sel", 8'h2, {device_selected, device_selected_single});
		oe_seen = 1'b0;
		scan_ir(RETURN_TO_ADDR_WAIT_CMD);
		chk("oe_seen", 8'h0, oe_seen);
		scan_ir(8'h3E);
		chk("sel", 8'h2, {device_selected, device_selected_single});
		scan_ir(RETURN_TO_ADDR_WAIT_CMD);
		group_member <= 1'b0;
		scan_ir(8'h3E);
		chk("selected", 8'h0, device_selected);
		scan_ir(RETURN_TO_ADDR_WAIT_CMD);
		scan_ir(8'h92);
		chk("single", 8'h1, device_selected_single);
		tap_to_reset();
		chk("selected", 8'h0, device_selected);
		scan_ir(8'h92);
		trst_b_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk("trst", 8'h0, local_trst_n_out);
		chk("tap", tap_reset, tap_state);
		chk("selected", 8'h0, device_selected);
		trst_b_n <= 1'b1;
		repeat (6) @(posedge clk);
		chk("trst", 8'h7, local_trst_n_out);
		$display("t_group done");
	endtask

	initial
	begin
		{rst_n, tck_b, tms_b, tdi_b, local_oe_n, oe_seen} = 6'h0;
		group_member = 1'b1;
		trst_b_n = 1'b1;
		err_count = 0;
		n_compared = 0;
		n_live = 0;
		repeat (3) @(posedge clk);
		chk("tap", tap_reset, tap_state);
		chk("lms", 8'h7, local_mode_select_out);
		chk("abe", 8'h0, port_analog_bus_enable);
		chk("selected", 8'h0, device_selected);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		chk("hiz", 8'h0, port_hiz_notify);
		chk("trst", 8'h7, local_trst_n_out);
		$display("t_reset done");
		t_unsel();
		t_single();
		t_decode();
		t_group();
		finish_test();
	end
endmodule // testbench
